/* File: shared/pgout_defs.vh */
`ifndef PGOUT_DEFS_VH
`define PGOUT_DEFS_VH

// ****************************************
// Bus geometry
// ****************************************
`define PGOUT_AW          22
`define PGOUT_DW          32
`define PGOUT_IDX_W       20
`define PGOUT_REG_W       8

// ****************************************
// Register indices (byte address is four times the index)
// ****************************************
`define PGOUT_IDX_TRIG_SEL  20'hFFFA1
`define PGOUT_IDX_UP_EN     20'hFFFA2
`define PGOUT_IDX_LO_EN     20'hFFFA3
`define PGOUT_IDX_UP_NEXT   20'hFFFA4
`define PGOUT_IDX_LO_NEXT   20'hFFFA5
`define PGOUT_IDX_UP_ALT    20'hFFFA6
`define PGOUT_IDX_LO_ALT    20'hFFFA7
`define PGOUT_IDX_LO_DATA   20'hFFFD9
`define PGOUT_IDX_UP_DATA   20'hFFFDA
`define PGOUT_IDX_LO_DIR    20'hEE009
`define PGOUT_IDX_UP_DIR    20'hEE00A

// ****************************************
// Reset values and constants
// ****************************************
`define PGOUT_RST_ZERO      8'h00
`define PGOUT_RST_TRIG_SEL  8'hFF
`define PGOUT_RSVD_BYTE     8'hFF
`define PGOUT_RSVD_NIB      4'hF
`define PGOUT_RESP_OKAY     2'h0
`define PGOUT_RESP_SLVERR   2'h2
`define PGOUT_CH0           2'h0
`define PGOUT_CH1           2'h1
`define PGOUT_CH2           2'h2
`define PGOUT_NUM_CH        3

// ****************************************
// Trigger select field positions
// ****************************************
`define PGOUT_G0_SEL        1:0
`define PGOUT_G1_SEL        3:2
`define PGOUT_G2_SEL        5:4
`define PGOUT_G3_SEL        7:6

`endif

/* File: logic/pgout_group.v */
`timescale 1ns/1ns
`include "pgout_defs.vh"

// ****************************************
// One 4-bit output group: trigger choice and masked transfer
// ****************************************
module pgout_group (
  input  wire [1:0]                 sel_in,
  input  wire [`PGOUT_NUM_CH-1:0]   match_pulse_in,
  input  wire [3:0]                 next_in,
  input  wire [3:0]                 enable_in,
  input  wire [3:0]                 cur_in,
  output reg  [1:0]                 chan_out,
  output reg                        fire_out,
  output reg  [3:0]                 data_out
);

  // Channel decode, both 1x codes pick channel 2
  always @* begin
    case (sel_in)
      2'b00:   chan_out = `PGOUT_CH0;
      2'b01:   chan_out = `PGOUT_CH1;
      default: chan_out = `PGOUT_CH2;
    endcase
    fire_out = match_pulse_in[chan_out];
    // Only enabled bits take the next value
    if (fire_out) begin
      data_out = (next_in & enable_in) | (cur_in & ~enable_in);
    end else begin
      data_out = cur_in;
    end
  end

endmodule

/* File: logic/pgout_top.v */
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "pgout_defs.vh"

// How it works
// - Lower port data register, eight bits, resets zero
// - Enabled lower data bits ignore software writes
// - Write-only upper direction register, resets zero
// - Upper port data register, eight bits, resets zero
// - Enabled upper data bits ignore software writes
// - Lower group trigger copies lower next bits
// - Lower next data cleared by reset, standby
// - Shared lower trigger: whole register at A5
// - Shared lower trigger: A7 reserved, reads ones
// - Separate lower triggers: split across A5, A7
// - Separate lower triggers: unused nibbles read ones
// - Upper group trigger copies upper next bits
// - Upper next data cleared by reset, standby
// - Shared upper trigger: whole register at A4
// - Shared upper trigger: A6 reserved, reads ones
// - Separate upper triggers: split across A4, A6
// - Separate upper triggers: unused nibbles read ones
// - Transfer only where enable bit set
// - Select code 00, 01, 1x picks channel
module pgout_top (
  input  wire                      clk_in,
  input  wire                      srst_in,
  input  wire                      hw_standby_in,
  input  wire [`PGOUT_NUM_CH-1:0]  cmp_match_in,
  input  wire [`PGOUT_AW-1:0]      s_axi_awaddr_in,
  input  wire [2:0]                s_axi_awprot_in,
  input  wire                      s_axi_awvalid_in,
  output wire                      s_axi_awready_out,
  input  wire [`PGOUT_DW-1:0]      s_axi_wdata_in,
  input  wire [3:0]                s_axi_wstrb_in,
  input  wire                      s_axi_wvalid_in,
  output wire                      s_axi_wready_out,
  output wire [1:0]                s_axi_bresp_out,
  output wire                      s_axi_bvalid_out,
  input  wire                      s_axi_bready_in,
  input  wire [`PGOUT_AW-1:0]      s_axi_araddr_in,
  input  wire [2:0]                s_axi_arprot_in,
  input  wire                      s_axi_arvalid_in,
  output wire                      s_axi_arready_out,
  output wire [`PGOUT_DW-1:0]      s_axi_rdata_out,
  output wire [1:0]                s_axi_rresp_out,
  output wire                      s_axi_rvalid_out,
  input  wire                      s_axi_rready_in,
  output wire [15:0]               pattern_out,
  output wire [7:0]                lower_dir_out,
  output wire [7:0]                upper_dir_out
);

  // ****************************************
  // Register state
  // ****************************************
  reg  [7:0]              lower_port_output_data_r;
  reg  [7:0]              upper_port_output_data_r;
  reg  [7:0]              lower_port_direction_r;
  reg  [7:0]              upper_port_direction_r;
  reg  [7:0]              lower_next_pattern_r;
  reg  [7:0]              upper_next_pattern_r;
  reg  [7:0]              lower_pattern_enable_r;
  reg  [7:0]              upper_pattern_enable_r;
  reg  [7:0]              group_trigger_select_r;
  reg  [`PGOUT_NUM_CH-1:0] match_prev_r;

  // ****************************************
  // Bus slave state
  // ****************************************
  reg                     aw_rdy_r;
  reg                     aw_hold_r;
  reg  [`PGOUT_AW-1:0]    aw_addr_r;
  reg                     w_rdy_r;
  reg                     w_hold_r;
  reg  [7:0]              w_data_r;
  reg                     w_lane_r;
  reg                     bvalid_r;
  reg  [1:0]              bresp_r;
  reg                     ar_rdy_r;
  reg                     rvalid_r;
  reg  [7:0]              rdata_r;
  reg  [1:0]              rresp_r;

  wire                    clear_all;
  wire                    aw_take;
  wire                    w_take;
  wire                    ar_take;
  wire                    do_write;
  wire [`PGOUT_IDX_W-1:0] w_idx;
  wire [`PGOUT_IDX_W-1:0] r_idx;
  wire                    w_aligned;
  wire                    r_aligned;
  wire [`PGOUT_NUM_CH-1:0] match_pulse;
  wire [1:0]              chan0;
  wire [1:0]              chan1;
  wire [1:0]              chan2;
  wire [1:0]              chan3;
  wire [7:0]              lower_after;
  wire [7:0]              upper_after;
  wire                    lower_shared;
  wire                    upper_shared;

  reg                     aw_hold_nxt;
  reg                     w_hold_nxt;
  reg                     bvalid_nxt;
  reg                     rvalid_nxt;
  reg                     wr_ok;
  reg                     rd_ok;
  reg  [7:0]              rd_val;
  reg  [7:0]              lower_data_nxt;
  reg  [7:0]              upper_data_nxt;
  reg  [7:0]              lower_next_nxt;
  reg  [7:0]              upper_next_nxt;

  // ****************************************
  // Handshake terms
  // ****************************************
  assign clear_all = srst_in | hw_standby_in;
  assign aw_take   = s_axi_awvalid_in & aw_rdy_r;
  assign w_take    = s_axi_wvalid_in & w_rdy_r;
  assign ar_take   = s_axi_arvalid_in & ar_rdy_r;
  assign do_write  = aw_hold_r & w_hold_r & ~bvalid_r;
  assign w_idx     = aw_addr_r[`PGOUT_AW-1:2];
  assign r_idx     = s_axi_araddr_in[`PGOUT_AW-1:2];
  assign w_aligned = (aw_addr_r[1:0] == 2'b00);
  assign r_aligned = (s_axi_araddr_in[1:0] == 2'b00);

  // Rising edge of each compare match gives a single pulse
  assign match_pulse = cmp_match_in & ~match_prev_r;

  // Pairs share a trigger when both groups pick one channel
  assign lower_shared = (chan0 == chan1);
  assign upper_shared = (chan2 == chan3);

  // ****************************************
  // Output groups
  // ****************************************
  pgout_group u_grp0 (
    .sel_in (group_trigger_select_r[`PGOUT_G0_SEL]), .match_pulse_in (match_pulse),
    .next_in (lower_next_pattern_r[3:0]), .enable_in (lower_pattern_enable_r[3:0]),
    .cur_in (lower_data_nxt[3:0]), .chan_out (chan0), .fire_out (), .data_out (lower_after[3:0])
  );

  pgout_group u_grp1 (
    .sel_in (group_trigger_select_r[`PGOUT_G1_SEL]), .match_pulse_in (match_pulse),
    .next_in (lower_next_pattern_r[7:4]), .enable_in (lower_pattern_enable_r[7:4]),
    .cur_in (lower_data_nxt[7:4]), .chan_out (chan1), .fire_out (), .data_out (lower_after[7:4])
  );

  pgout_group u_grp2 (
    .sel_in (group_trigger_select_r[`PGOUT_G2_SEL]), .match_pulse_in (match_pulse),
    .next_in (upper_next_pattern_r[3:0]), .enable_in (upper_pattern_enable_r[3:0]),
    .cur_in (upper_data_nxt[3:0]), .chan_out (chan2), .fire_out (), .data_out (upper_after[3:0])
  );

  pgout_group u_grp3 (
    .sel_in (group_trigger_select_r[`PGOUT_G3_SEL]), .match_pulse_in (match_pulse),
    .next_in (upper_next_pattern_r[7:4]), .enable_in (upper_pattern_enable_r[7:4]),
    .cur_in (upper_data_nxt[7:4]), .chan_out (chan3), .fire_out (), .data_out (upper_after[7:4])
  );

  // ****************************************
  // Write decode
  // ****************************************
  always @* begin
    wr_ok          = 1'b1;
    lower_data_nxt = lower_port_output_data_r;
    upper_data_nxt = upper_port_output_data_r;
    lower_next_nxt = lower_next_pattern_r;
    upper_next_nxt = upper_next_pattern_r;
    if (!w_aligned) begin
      wr_ok = 1'b0;
    end else begin
      case (w_idx)
        `PGOUT_IDX_TRIG_SEL, `PGOUT_IDX_UP_EN, `PGOUT_IDX_LO_EN,
        `PGOUT_IDX_LO_DIR, `PGOUT_IDX_UP_DIR: wr_ok = 1'b1;
        `PGOUT_IDX_LO_DATA: begin
          // Enabled bits keep their value
          if (do_write && w_lane_r) begin
            lower_data_nxt = (lower_port_output_data_r & lower_pattern_enable_r)
                           | (w_data_r & ~lower_pattern_enable_r);
          end
        end
        `PGOUT_IDX_UP_DATA: begin
          if (do_write && w_lane_r) begin
            upper_data_nxt = (upper_port_output_data_r & upper_pattern_enable_r)
                           | (w_data_r & ~upper_pattern_enable_r);
          end
        end
        `PGOUT_IDX_LO_NEXT: begin
          if (do_write && w_lane_r) begin
            if (lower_shared) begin
              lower_next_nxt = w_data_r;
            end else begin
              lower_next_nxt[7:4] = w_data_r[7:4];
            end
          end
        end
        `PGOUT_IDX_LO_ALT: begin
          // Whole byte reserved while the pair shares a trigger
          if (do_write && w_lane_r && !lower_shared) begin
            lower_next_nxt[3:0] = w_data_r[3:0];
          end
        end
        `PGOUT_IDX_UP_NEXT: begin
          if (do_write && w_lane_r) begin
            if (upper_shared) begin
              upper_next_nxt = w_data_r;
            end else begin
              upper_next_nxt[7:4] = w_data_r[7:4];
            end
          end
        end
        `PGOUT_IDX_UP_ALT: begin
          if (do_write && w_lane_r && !upper_shared) begin
            upper_next_nxt[3:0] = w_data_r[3:0];
          end
        end
        default: wr_ok = 1'b0;
      endcase
    end
  end

  // ****************************************
  // Read decode
  // ****************************************
  always @* begin
    rd_ok  = 1'b1;
    rd_val = `PGOUT_RST_ZERO;
    if (!r_aligned) begin
      rd_ok = 1'b0;
    end else begin
      case (r_idx)
        `PGOUT_IDX_TRIG_SEL: rd_val = group_trigger_select_r;
        `PGOUT_IDX_UP_EN:    rd_val = upper_pattern_enable_r;
        `PGOUT_IDX_LO_EN:    rd_val = lower_pattern_enable_r;
        `PGOUT_IDX_LO_DATA:  rd_val = lower_port_output_data_r;
        `PGOUT_IDX_UP_DATA:  rd_val = upper_port_output_data_r;
        // Direction registers are write-only and read as zero
        `PGOUT_IDX_LO_DIR:   rd_val = `PGOUT_RST_ZERO;
        `PGOUT_IDX_UP_DIR:   rd_val = `PGOUT_RST_ZERO;
        `PGOUT_IDX_LO_NEXT:  rd_val = lower_shared ? lower_next_pattern_r
                             : {lower_next_pattern_r[7:4], `PGOUT_RSVD_NIB};
        `PGOUT_IDX_LO_ALT:   rd_val = lower_shared ? `PGOUT_RSVD_BYTE
                             : {`PGOUT_RSVD_NIB, lower_next_pattern_r[3:0]};
        `PGOUT_IDX_UP_NEXT:  rd_val = upper_shared ? upper_next_pattern_r
                             : {upper_next_pattern_r[7:4], `PGOUT_RSVD_NIB};
        `PGOUT_IDX_UP_ALT:   rd_val = upper_shared ? `PGOUT_RSVD_BYTE
                             : {`PGOUT_RSVD_NIB, upper_next_pattern_r[3:0]};
        default:             rd_ok = 1'b0;
      endcase
    end
  end

  // ****************************************
  // Channel state next values
  // ****************************************
  always @* begin
    aw_hold_nxt = do_write ? 1'b0 : (aw_hold_r | aw_take);
    w_hold_nxt  = do_write ? 1'b0 : (w_hold_r | w_take);
    bvalid_nxt  = do_write | (bvalid_r & ~s_axi_bready_in);
    rvalid_nxt  = ar_take | (rvalid_r & ~s_axi_rready_in);
  end

  // Bus slave registers
  always @(posedge clk_in) begin
    if (srst_in) begin
      aw_rdy_r  <= 1'b0;
      aw_hold_r <= 1'b0;
      aw_addr_r <= {`PGOUT_AW{1'b0}};
      w_rdy_r   <= 1'b0;
      w_hold_r  <= 1'b0;
      w_data_r  <= `PGOUT_RST_ZERO;
      w_lane_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `PGOUT_RESP_OKAY;
      ar_rdy_r  <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= `PGOUT_RST_ZERO;
      rresp_r   <= `PGOUT_RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      bvalid_r  <= bvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      aw_rdy_r  <= ~aw_hold_nxt & ~bvalid_nxt;
      w_rdy_r   <= ~w_hold_nxt & ~bvalid_nxt;
      ar_rdy_r  <= ~rvalid_nxt;
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr_in;
      end
      if (w_take) begin
        w_data_r <= s_axi_wdata_in[7:0];
        w_lane_r <= s_axi_wstrb_in[0];
      end
      if (do_write) begin
        bresp_r <= wr_ok ? `PGOUT_RESP_OKAY : `PGOUT_RESP_SLVERR;
      end
      if (ar_take) begin
        rdata_r <= rd_val;
        rresp_r <= rd_ok ? `PGOUT_RESP_OKAY : `PGOUT_RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // Unit registers, cleared by reset and hardware standby
  // ****************************************
  always @(posedge clk_in) begin
    if (clear_all) begin
      lower_port_output_data_r <= `PGOUT_RST_ZERO;
      upper_port_output_data_r <= `PGOUT_RST_ZERO;
      lower_port_direction_r   <= `PGOUT_RST_ZERO;
      upper_port_direction_r   <= `PGOUT_RST_ZERO;
      lower_next_pattern_r     <= `PGOUT_RST_ZERO;
      upper_next_pattern_r     <= `PGOUT_RST_ZERO;
      lower_pattern_enable_r   <= `PGOUT_RST_ZERO;
      upper_pattern_enable_r   <= `PGOUT_RST_ZERO;
      group_trigger_select_r   <= `PGOUT_RST_TRIG_SEL;
      match_prev_r             <= {`PGOUT_NUM_CH{1'b0}};
    end else begin
      match_prev_r <= cmp_match_in;
      // Group transfers; a shared pair fires in the same cycle
      lower_port_output_data_r <= lower_after;
      upper_port_output_data_r <= upper_after;
      lower_next_pattern_r     <= lower_next_nxt;
      upper_next_pattern_r     <= upper_next_nxt;
      if (do_write && w_lane_r && w_aligned) begin
        case (w_idx)
          `PGOUT_IDX_TRIG_SEL: group_trigger_select_r <= w_data_r;
          `PGOUT_IDX_UP_EN:    upper_pattern_enable_r <= w_data_r;
          `PGOUT_IDX_LO_EN:    lower_pattern_enable_r <= w_data_r;
          `PGOUT_IDX_LO_DIR:   lower_port_direction_r <= w_data_r;
          `PGOUT_IDX_UP_DIR:   upper_port_direction_r <= w_data_r;
          default: group_trigger_select_r <= group_trigger_select_r;
        endcase
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready_out = aw_rdy_r;
  assign s_axi_wready_out  = w_rdy_r;
  assign s_axi_bvalid_out  = bvalid_r;
  assign s_axi_bresp_out   = bresp_r;
  assign s_axi_arready_out = ar_rdy_r;
  assign s_axi_rvalid_out  = rvalid_r;
  assign s_axi_rresp_out   = rresp_r;
  assign s_axi_rdata_out   = {24'h000000, rdata_r};
  assign pattern_out       = {upper_port_output_data_r, lower_port_output_data_r};
  assign lower_dir_out     = lower_port_direction_r;
  assign upper_dir_out     = upper_port_direction_r;

endmodule

/* File: verif/podr_timer_model.sv */
`timescale 1ns/1ns
// ****************************************
// Timer compare-match source
// ****************************************
module podr_timer_model (
  input  wire       clk_in,
  input  wire       srst_in,
  input  wire [2:0] req_in,
  output reg  [2:0] cmp_match_out
);
  // Match lines follow the request one cycle late
  always @(posedge clk_in) begin
    if (srst_in) begin
      cmp_match_out <= 3'h0;
    end else begin
      cmp_match_out <= req_in;
    end
  end
endmodule

/* File: verif/podr_props.sv */
`timescale 1ns/1ns
// ****************************************
// Port checker
// ****************************************
module podr_props (
  input wire        clk_in,
  input wire        srst_in,
  input wire        hw_standby_in,
  input wire [2:0]  cmp_match_in,
  input wire [21:0] s_axi_araddr_in,
  input wire        s_axi_awvalid_in,
  input wire        s_axi_awready_out,
  input wire        s_axi_wvalid_in,
  input wire        s_axi_wready_out,
  input wire [1:0]  s_axi_bresp_out,
  input wire        s_axi_bvalid_out,
  input wire        s_axi_bready_in,
  input wire        s_axi_arvalid_in,
  input wire        s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire [1:0]  s_axi_rresp_out,
  input wire        s_axi_rvalid_out,
  input wire        s_axi_rready_in,
  input wire [15:0] pattern_out,
  input wire [7:0]  lower_dir_out,
  input wire [7:0]  upper_dir_out
);
  reg  [2:0] prev_r;
  reg  [2:0] wr_r;
  wire       rise = |(cmp_match_in & ~prev_r);
  wire       wtk = s_axi_awvalid_in && s_axi_awready_out || s_axi_wvalid_in && s_axi_wready_out;
  // Match history and recent bus writes
  always @(posedge clk_in) begin
    prev_r <= (srst_in || hw_standby_in) ? 3'h0 : cmp_match_in;
    wr_r   <= srst_in ? 3'h0 : {wr_r[1:0], wtk};
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  rst_clear_a: assert property (disable iff (1'b0) srst_in || hw_standby_in |=>
    pattern_out == 16'h0000 && lower_dir_out == 8'h00 && upper_dir_out == 8'h00)
    else $error("outputs not cleared");
  out_hold_a: assert property (!$past(rise) && wr_r == 3'h0 && !$past(hw_standby_in) &&
    !$past(srst_in) |-> $stable(pattern_out)) else $error("pattern changed without cause");
  wr_lat_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
    s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out) else $error("write answer late");
  rd_lat_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer dropped");
  b_busy_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while answer pending");
  rd_err_a: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[1:0] != 2'h0
    |=> s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 32'h0) else $error("unaligned read ok");
  rd_upper_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
    else $error("read data upper bits set");
endmodule
bind pgout_top podr_props u_podr_props (
  .clk_in(clk_in), .srst_in(srst_in), .hw_standby_in(hw_standby_in),
  .cmp_match_in(cmp_match_in), .s_axi_araddr_in(s_axi_araddr_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in), .pattern_out(pattern_out),
  .lower_dir_out(lower_dir_out), .upper_dir_out(upper_dir_out)
);

/* File: verif/pattern_output_data_regs_tb_top.sv */
`timescale 1ns/1ns
`include "pgout_defs.vh"
// ****************************************
// Bench top
// ****************************************
module pattern_output_data_regs_tb_top;
  localparam [1:0] OK = `PGOUT_RESP_OKAY;
  localparam [1:0] ER = `PGOUT_RESP_SLVERR;
  reg         clk_in = 1'b0;
  reg         srst_in = 1'b1;
  reg         stby = 1'b0;
  reg  [2:0]  req = 3'h0;
  reg  [2:0]  prot = 3'h0;
  reg  [3:0]  strb = 4'hF;
  reg  [21:0] awaddr = 22'h0;
  reg  [21:0] araddr = 22'h0;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'b0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  wire [2:0]  cmp;
  wire [31:0] rdata;
  wire [1:0]  bresp;
  wire [1:0]  rresp;
  wire [15:0] pat;
  wire [7:0]  ldir;
  wire [7:0]  udir;
  wire        awready;
  wire        wready;
  wire        bvalid;
  wire        arready;
  wire        rvalid;
  integer     mismatches = 0;
  integer     check_count = 0;
  always #2 clk_in = ~clk_in;
  podr_timer_model u_podr_timer_model (.clk_in(clk_in), .srst_in(srst_in), .req_in(req),
    .cmp_match_out(cmp));
  pgout_top u_pgout_top (.clk_in(clk_in), .srst_in(srst_in), .hw_standby_in(stby),
    .cmp_match_in(cmp), .s_axi_awaddr_in(awaddr), .s_axi_awprot_in(prot),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arprot_in(prot), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .pattern_out(pat),
    .lower_dir_out(ldir), .upper_dir_out(udir));
  task give_verdict;
    if (mismatches == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tmo(input integer n);
    if (n >= 64) begin
      mismatches = mismatches + 1;
      $display("FAIL %0t bus wait ran out", $time);
      give_verdict;
    end
  endtask
  function [21:0] ba(input [19:0] idx);
    ba = {idx, 2'h0};
  endfunction
  // Bus write of one register word
  task wr(input [19:0] idx, input [7:0] d, input [1:0] er);
    integer n;
    n = 0;
    @(posedge clk_in);
    awaddr <= ba(idx);
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n = n + 1;
    end while ((awvalid && !awready || wvalid && !wready) && n < 64);
    tmo(n);
    do begin
      @(posedge clk_in);
      n = n + 1;
    end while (!bvalid && n < 64);
    tmo(n);
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask
  // Bus read with expected word and response
  task rd(input [21:0] a, input [7:0] d, input [1:0] er);
    integer n;
    n = 0;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      n = n + 1;
    end while (!arready && n < 64);
    arvalid <= 1'b0;
    tmo(n);
    do begin
      @(posedge clk_in);
      n = n + 1;
    end while (!rvalid && n < 64);
    tmo(n);
    chk(rdata, {24'h0, d});
    chk({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask
  // One compare-match request lasting h cycles
  task fire(input [2:0] m, input integer h);
    req <= m;
    repeat (h) @(posedge clk_in);
    req <= 3'h0;
    repeat (3) @(posedge clk_in);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(ba(`PGOUT_IDX_LO_NEXT), 8'h00, OK);
    rd(ba(`PGOUT_IDX_UP_NEXT), 8'h00, OK);
    rd(ba(`PGOUT_IDX_LO_DATA), 8'h00, OK);
    rd(ba(`PGOUT_IDX_UP_DATA), 8'h00, OK);
    wr(`PGOUT_IDX_UP_DIR, 8'hFF, OK);
    wr(`PGOUT_IDX_LO_DIR, 8'hFF, OK);
    chk({16'h0, udir, ldir}, 32'hFFFF);
    rd(ba(`PGOUT_IDX_UP_DIR), 8'h00, OK);
    wr(`PGOUT_IDX_LO_NEXT, 8'h5A, OK);
    wr(`PGOUT_IDX_UP_NEXT, 8'hC3, OK);
    wr(`PGOUT_IDX_LO_ALT, 8'h00, OK);
    wr(`PGOUT_IDX_UP_ALT, 8'h00, OK);
    rd(ba(`PGOUT_IDX_LO_NEXT), 8'h5A, OK);
    rd(ba(`PGOUT_IDX_UP_NEXT), 8'hC3, OK);
    rd(ba(`PGOUT_IDX_LO_ALT), 8'hFF, OK);
    rd(ba(`PGOUT_IDX_UP_ALT), 8'hFF, OK);
    wr(`PGOUT_IDX_LO_EN, 8'hFF, OK);
    wr(`PGOUT_IDX_UP_EN, 8'hF0, OK);
    fire(3'h3, 1);
    chk({16'h0, pat}, 32'h0);
    fire(3'h4, 1);
    chk({16'h0, pat}, 32'hC05A);
    wr(`PGOUT_IDX_UP_DATA, 8'hFF, OK);
    rd(ba(`PGOUT_IDX_UP_DATA), 8'hCF, OK);
    wr(`PGOUT_IDX_LO_EN, 8'h0F, OK);
    wr(`PGOUT_IDX_LO_DATA, 8'hFF, OK);
    rd(ba(`PGOUT_IDX_LO_DATA), 8'hFA, OK);
    // Held match line: one transfer only
    wr(`PGOUT_IDX_UP_NEXT, 8'h96, OK);
    req <= 3'h4;
    repeat (2) @(posedge clk_in);
    wr(`PGOUT_IDX_UP_NEXT, 8'h30, OK);
    chk({16'h0, pat}, 32'h9FFA);
    fire(3'h0, 1);
    chk({16'h0, pat}, 32'h9FFA);
    // Separate lower triggers, shared upper via codes 10 and 11
    wr(`PGOUT_IDX_TRIG_SEL, 8'hE4, OK);
    wr(`PGOUT_IDX_LO_EN, 8'hFF, OK);
    wr(`PGOUT_IDX_UP_EN, 8'hFF, OK);
    wr(`PGOUT_IDX_LO_ALT, 8'h09, OK);
    wr(`PGOUT_IDX_LO_NEXT, 8'h30, OK);
    rd(ba(`PGOUT_IDX_LO_NEXT), 8'h3F, OK);
    rd(ba(`PGOUT_IDX_LO_ALT), 8'hF9, OK);
    rd(ba(`PGOUT_IDX_UP_ALT), 8'hFF, OK);
    fire(3'h1, 1);
    chk({16'h0, pat}, 32'h9FF9);
    fire(3'h2, 1);
    chk({16'h0, pat}, 32'h9F39);
    fire(3'h4, 1);
    chk({16'h0, pat}, 32'h3039);
    // Separate upper triggers
    wr(`PGOUT_IDX_TRIG_SEL, 8'h44, OK);
    wr(`PGOUT_IDX_UP_ALT, 8'h56, OK);
    wr(`PGOUT_IDX_UP_NEXT, 8'hA5, OK);
    wr(`PGOUT_IDX_LO_ALT, 8'h02, OK);
    rd(ba(`PGOUT_IDX_UP_NEXT), 8'hAF, OK);
    rd(ba(`PGOUT_IDX_UP_ALT), 8'hF6, OK);
    fire(3'h1, 1);
    chk({16'h0, pat}, 32'h3632);
    fire(3'h2, 1);
    chk({16'h0, pat}, 32'hA632);
    // Unmapped and unaligned accesses
    wr(20'h00010, 8'h11, ER);
    rd(ba(20'h00010), 8'h00, ER);
    rd(ba(`PGOUT_IDX_LO_NEXT) | 22'h1, 8'h00, ER);
    // Byte lane 0 off: write answered but ignored
    strb <= 4'hE;
    wr(`PGOUT_IDX_LO_NEXT, 8'h77, OK);
    strb <= 4'hF;
    rd(ba(`PGOUT_IDX_LO_NEXT), 8'h3F, OK);
    // Hardware standby clears the unit
    @(posedge clk_in);
    stby <= 1'b1;
    @(posedge clk_in);
    stby <= 1'b0;
    @(posedge clk_in);
    chk({udir, ldir, pat}, 32'h0);
    rd(ba(`PGOUT_IDX_LO_NEXT), 8'h00, OK);
    rd(ba(`PGOUT_IDX_UP_NEXT), 8'h00, OK);
    rd(ba(`PGOUT_IDX_LO_ALT), 8'hFF, OK);
    give_verdict;
  end
endmodule
